// ===== logic/pmc_regs.v
/*
 Misc control register bank of an Ethernet transceiver, reached over
 AXI4-Lite. Assumes a single 125 MHz clock, drop events from the PHY
 core as asynchronous levels/pulses, and a core that honours the reset
 and control outputs.
*/
// Notes on behaviour
// RULE1: Bit 15 write: full reset, registers default
// RULE2: Bit 14 write: core restart, registers kept
// RULE3: Control bits 13:0 ignore writes, read zero
// RULE4: Select bit 7 drives all four channels
// RULE5: Bits 6:5 pick channel A to D
// RULE6: Link drop enable bit, resets zero
// RULE7: Gigabit link drop configuration bit
// RULE8: Cause bits 12:8 latch on drop
// RULE9: Cause map: sync, rx, mlt3, snr, energy
// RULE10: Cause latches only if source enabled
// RULE11: Bits 4:0 enable each drop source
// RULE12: Mirror bit 0 enables port mirroring
// RULE13: Mac interface enable bit, defaults one
// RULE14: Receive fifo half level, default 10
// RULE15: Transmit fifo half level, default 10
// RULE16: Transmit level sets fifo half point
// RULE17: Cause bits clear on read, relatch
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_regs (
	// Clock and reset
	input  wire        CLOCK_IN,
	input  wire        ARST_N_IN,
	// AXI4-Lite write
	input  wire [31:0] AWADDR_IN,
	input  wire        AWVALID_IN,
	output reg         AWREADY_OUT,
	input  wire [31:0] WDATA_IN,
	input  wire [3:0]  WSTRB_IN,
	input  wire        WVALID_IN,
	output reg         WREADY_OUT,
	output reg  [1:0]  BRESP_OUT,
	output reg         BVALID_OUT,
	input  wire        BREADY_IN,
	// AXI4-Lite read
	input  wire [31:0] ARADDR_IN,
	input  wire        ARVALID_IN,
	output reg         ARREADY_OUT,
	output reg  [31:0] RDATA_OUT,
	output reg  [1:0]  RRESP_OUT,
	output reg         RVALID_OUT,
	input  wire        RREADY_IN,
	// Drop criteria from the PHY core
	input  wire [4:0]  DROP_EVENT_IN,
	// Controls to the PHY core
	output reg         CORE_RESET_OUT,
	output reg  [3:0]  TEST_CHAN_EN_OUT,
	output reg         LINK_DROP_ENABLE_OUT,
	output reg         LINK_DROP_GIGABIT_CFG_OUT,
	output reg  [4:0]  LINK_DROP_SOURCE_MASK_OUT,
	output reg         PORT_MIRROR_OUT,
	output reg         MAC_PORT_ENABLE_OUT,
	output reg  [1:0]  RX_FIFO_HALF_LEVEL_OUT,
	output reg  [1:0]  TX_FIFO_HALF_LEVEL_OUT,
	// Interrupt
	output reg         IRQ_OUT
);

	localparam ST_IDLE = 3'b001;
	localparam ST_BRSP = 3'b010;
	localparam ST_RRSP = 3'b100;

	// Reset value of the mac port control register
	localparam [7:0] MAC_RST = `PMC_MAC_PORT_RST;
	// One-hot enable of test channel A
	localparam [3:0] CHAN_A  = 4'h1;

	reg [2:0]  wstate;
	reg [2:0]  rstate;
	reg        aw_held;
	reg        w_held;
	reg [31:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg [4:0]  ev_meta;
	reg [4:0]  ev_sync;
	reg [4:0]  ev_prev;
	reg        test_all;
	reg [1:0]  test_sel;
	reg        ld_enable;
	reg        ld_gig;
	reg [4:0]  ld_cause;
	reg [4:0]  ld_src;
	reg        mirror_en;
	reg        mac_en;
	reg [1:0]  rx_half;
	reg [1:0]  tx_half;
	reg [4:0]  irq_status;
	reg [4:0]  irq_mask;
	reg [3:0]  rst_count;
	reg        soft_full_reset;
	reg [15:0] next_rdata;
	reg [1:0]  next_rresp;

	// Register index from a byte address; 0xFF marks a bad address
	function [7:0] reg_index;
		input [31:0] addr;
		begin
			if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0)
				reg_index = 8'hFF;
			else
				reg_index = addr[9:2];
		end
	endfunction

	// Whether an index names a mapped register
	function mapped;
		input [7:0] idx;
		begin
			case (idx)
				`PMC_IDX_RESET_CTRL, `PMC_IDX_TEST_CHAN, `PMC_IDX_LINK_DROP,
				`PMC_IDX_MIRROR, `PMC_IDX_MAC_PORT, `PMC_IDX_IRQ_STATUS,
				`PMC_IDX_IRQ_MASK: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	wire       aw_have = aw_held | (AWVALID_IN & AWREADY_OUT);
	wire       w_have  = w_held | (WVALID_IN & WREADY_OUT);
	wire [31:0] cur_aw = aw_held ? aw_addr : AWADDR_IN;
	wire [31:0] cur_wd = w_held ? w_data : WDATA_IN;
	wire [3:0]  cur_ws = w_held ? w_strb : WSTRB_IN;
	wire        do_write = (wstate == ST_IDLE) && aw_have && w_have;
	wire [7:0]  widx = reg_index(cur_aw);
	wire        wlo = cur_ws[0];
	wire        whi = cur_ws[1];
	wire        rd_take = ARVALID_IN & ARREADY_OUT;
	wire [7:0]  ridx = reg_index(ARADDR_IN);
	// Self-clearing commands act on the write and are never stored
	wire        wr_full_reset = do_write && widx == `PMC_IDX_RESET_CTRL && whi
		&& cur_wd[`PMC_FULL_RESET_BIT];
	wire        wr_restart = do_write && widx == `PMC_IDX_RESET_CTRL && whi
		&& cur_wd[`PMC_RESTART_BIT];
	wire [4:0]  ev_rise = ev_sync & ~ev_prev;
	wire [4:0]  ev_hit = ev_rise & ld_src & {5{ld_enable}}; // RULE10

	// Read mux
	always @* begin
		next_rdata = 16'h0000;
		next_rresp = `PMC_RESP_OKAY;
		case (ridx)
			`PMC_IDX_RESET_CTRL: next_rdata = 16'h0000; // RULE3
			`PMC_IDX_TEST_CHAN:
				next_rdata = `PMC_TEST_CHAN_RST | {8'h00, test_all, test_sel, 5'h00};
			`PMC_IDX_LINK_DROP:
				next_rdata = {ld_enable, ld_gig, 1'b0, ld_cause, 3'h0, ld_src}; // RULE9
			`PMC_IDX_MIRROR: next_rdata = `PMC_MIRROR_RST | {15'h0000, mirror_en};
			`PMC_IDX_MAC_PORT: next_rdata = {8'h00, mac_en, rx_half, tx_half, 3'h0};
			`PMC_IDX_IRQ_STATUS: next_rdata = {11'h000, irq_status};
			`PMC_IDX_IRQ_MASK: next_rdata = {11'h000, irq_mask};
			default: next_rresp = `PMC_RESP_SLVERR;
		endcase
	end

	// Event synchroniser
	always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ev_meta <= 5'h00;
			ev_sync <= 5'h00;
			ev_prev <= 5'h00;
		end else begin
			ev_meta <= DROP_EVENT_IN;
			ev_sync <= ev_meta;
			ev_prev <= ev_sync;
		end
	end

	// Bus handshakes
	always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wstate      <= ST_IDLE;
			rstate      <= ST_IDLE;
			aw_held     <= 1'b0;
			w_held      <= 1'b0;
			aw_addr     <= 32'h00000000;
			w_data      <= 32'h00000000;
			w_strb      <= 4'h0;
			AWREADY_OUT <= 1'b1;
			WREADY_OUT  <= 1'b1;
			BVALID_OUT  <= 1'b0;
			BRESP_OUT   <= `PMC_RESP_OKAY;
			ARREADY_OUT <= 1'b1;
			RVALID_OUT  <= 1'b0;
			RRESP_OUT   <= `PMC_RESP_OKAY;
			RDATA_OUT   <= 32'h00000000;
		end else begin
			case (wstate)
				ST_IDLE: begin
					if (do_write) begin
						wstate      <= ST_BRSP;
						aw_held     <= 1'b0;
						w_held      <= 1'b0;
						AWREADY_OUT <= 1'b0;
						WREADY_OUT  <= 1'b0;
						BVALID_OUT  <= 1'b1;
						BRESP_OUT   <= mapped(widx) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
					end else begin
						if (AWVALID_IN & AWREADY_OUT) begin
							aw_held     <= 1'b1;
							aw_addr     <= AWADDR_IN;
							AWREADY_OUT <= 1'b0;
						end
						if (WVALID_IN & WREADY_OUT) begin
							w_held     <= 1'b1;
							w_data     <= WDATA_IN;
							w_strb     <= WSTRB_IN;
							WREADY_OUT <= 1'b0;
						end
					end
				end
				ST_BRSP: begin
					if (BREADY_IN) begin
						wstate      <= ST_IDLE;
						BVALID_OUT  <= 1'b0;
						AWREADY_OUT <= 1'b1;
						WREADY_OUT  <= 1'b1;
					end
				end
				default: wstate <= ST_IDLE;
			endcase
			case (rstate)
				ST_IDLE: begin
					if (rd_take) begin
						rstate      <= ST_RRSP;
						ARREADY_OUT <= 1'b0;
						RVALID_OUT  <= 1'b1;
						RDATA_OUT   <= {16'h0000, next_rdata};
						RRESP_OUT   <= next_rresp;
					end
				end
				ST_RRSP: begin
					if (RREADY_IN) begin
						rstate      <= ST_IDLE;
						RVALID_OUT  <= 1'b0;
						ARREADY_OUT <= 1'b1;
					end
				end
				default: rstate <= ST_IDLE;
			endcase
		end
	end

	// Reset pulse for the core; full reset also restores registers
	always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_count       <= 4'h0;
			soft_full_reset <= 1'b0;
			CORE_RESET_OUT  <= 1'b0;
		end else begin
			soft_full_reset <= wr_full_reset; // RULE1
			if (wr_full_reset | wr_restart) begin
				rst_count      <= `PMC_RESET_PULSE_CYC; // RULE2
				CORE_RESET_OUT <= 1'b1;
			end else if (rst_count != 4'h0) begin
				rst_count      <= rst_count - 4'h1;
				CORE_RESET_OUT <= (rst_count != 4'h1);
			end else begin
				CORE_RESET_OUT <= 1'b0;
			end
		end
	end

	// Writable registers
	always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			test_all  <= 1'b0;
			test_sel  <= 2'h0;
			ld_enable <= 1'b0;
			ld_gig    <= 1'b0;
			ld_src    <= 5'h00;
			mirror_en <= 1'b0;
			mac_en    <= MAC_RST[`PMC_MAC_EN_BIT];
			rx_half   <= MAC_RST[`PMC_RX_HALF_HI:`PMC_RX_HALF_LO];
			tx_half   <= MAC_RST[`PMC_TX_HALF_HI:`PMC_TX_HALF_LO];
			irq_mask  <= 5'h00;
		end else if (soft_full_reset) begin
			test_all  <= 1'b0; // RULE1
			test_sel  <= 2'h0;
			ld_enable <= 1'b0;
			ld_gig    <= 1'b0;
			ld_src    <= 5'h00;
			mirror_en <= 1'b0;
			mac_en    <= MAC_RST[`PMC_MAC_EN_BIT];
			rx_half   <= MAC_RST[`PMC_RX_HALF_HI:`PMC_RX_HALF_LO];
			tx_half   <= MAC_RST[`PMC_TX_HALF_HI:`PMC_TX_HALF_LO];
			irq_mask  <= 5'h00;
		end else if (do_write) begin
			// Lower byte fields
			if (wlo) begin
				case (widx)
					`PMC_IDX_TEST_CHAN: begin
						test_all <= cur_wd[`PMC_TCH_ALL_BIT];
						test_sel <= cur_wd[`PMC_TCH_SEL_HI:`PMC_TCH_SEL_LO];
					end
					`PMC_IDX_LINK_DROP: ld_src <= cur_wd[`PMC_LD_SRC_HI:`PMC_LD_SRC_LO]; // RULE11
					`PMC_IDX_MIRROR: mirror_en <= cur_wd[`PMC_MIRROR_BIT]; // RULE12
					`PMC_IDX_MAC_PORT: begin
						mac_en  <= cur_wd[`PMC_MAC_EN_BIT]; // RULE13
						rx_half <= cur_wd[`PMC_RX_HALF_HI:`PMC_RX_HALF_LO]; // RULE14
						tx_half <= cur_wd[`PMC_TX_HALF_HI:`PMC_TX_HALF_LO]; // RULE15
					end
					`PMC_IDX_IRQ_MASK: irq_mask <= cur_wd[4:0];
					default: ;
				endcase
			end
			// Upper byte holds the link drop enable and gigabit bits
			if (whi && widx == `PMC_IDX_LINK_DROP) begin
				ld_enable <= cur_wd[`PMC_LD_ENABLE_BIT]; // RULE6
				ld_gig    <= cur_wd[`PMC_LD_GIG_BIT]; // RULE7
			end
		end
	end

	// Latched causes and interrupt status; a new event wins over the read clear
	always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ld_cause   <= 5'h00;
			irq_status <= 5'h00;
		end else if (soft_full_reset) begin
			ld_cause   <= 5'h00;
			irq_status <= 5'h00;
		end else begin
			if (rd_take && ridx == `PMC_IDX_LINK_DROP)
				ld_cause <= ev_hit; // RULE17
			else
				ld_cause <= ld_cause | ev_hit; // RULE8
			if (rd_take && ridx == `PMC_IDX_IRQ_STATUS)
				irq_status <= ev_hit;
			else
				irq_status <= irq_status | ev_hit;
		end
	end

	// Registered outputs to the core
	always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			TEST_CHAN_EN_OUT          <= CHAN_A;
			LINK_DROP_ENABLE_OUT      <= 1'b0;
			LINK_DROP_GIGABIT_CFG_OUT <= 1'b0;
			LINK_DROP_SOURCE_MASK_OUT <= 5'h00;
			PORT_MIRROR_OUT           <= 1'b0;
			MAC_PORT_ENABLE_OUT       <= MAC_RST[`PMC_MAC_EN_BIT];
			RX_FIFO_HALF_LEVEL_OUT    <= MAC_RST[`PMC_RX_HALF_HI:`PMC_RX_HALF_LO];
			TX_FIFO_HALF_LEVEL_OUT    <= MAC_RST[`PMC_TX_HALF_HI:`PMC_TX_HALF_LO];
			IRQ_OUT                   <= 1'b0;
		end else begin
			// Select bit 7 overrides the single-channel code
			if (test_all)
				TEST_CHAN_EN_OUT <= 4'hF; // RULE4
			else
				TEST_CHAN_EN_OUT <= CHAN_A << test_sel; // RULE5
			LINK_DROP_ENABLE_OUT      <= ld_enable;
			LINK_DROP_GIGABIT_CFG_OUT <= ld_gig;
			LINK_DROP_SOURCE_MASK_OUT <= ld_src;
			PORT_MIRROR_OUT           <= mirror_en;
			MAC_PORT_ENABLE_OUT       <= mac_en;
			RX_FIFO_HALF_LEVEL_OUT    <= rx_half;
			TX_FIFO_HALF_LEVEL_OUT    <= tx_half; // RULE16
			IRQ_OUT                   <= |(irq_status & irq_mask);
		end
	end

endmodule // pmc_regs

// ===== logic/pmc_defines.vh
/*
 Register offsets, field positions, reset values and bus codes for the
 misc control register bank. Assumes inclusion by bare name.
*/
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// Register indices; byte address is four times the index
`define PMC_IDX_RESET_CTRL    8'h1F
`define PMC_IDX_TEST_CHAN     8'h25
`define PMC_IDX_LINK_DROP     8'h2D
`define PMC_IDX_MIRROR        8'h31
`define PMC_IDX_MAC_PORT      8'h32
`define PMC_IDX_IRQ_STATUS    8'h40
`define PMC_IDX_IRQ_MASK      8'h41

// Control register fields
`define PMC_FULL_RESET_BIT    15
`define PMC_RESTART_BIT       14

// Test channel select field
`define PMC_TCH_ALL_BIT       7
`define PMC_TCH_SEL_HI        6
`define PMC_TCH_SEL_LO        5
`define PMC_TEST_CHAN_RST     16'h0400
`define PMC_TEST_CHAN_WMASK   16'h00E0

// Link drop register fields
`define PMC_LD_ENABLE_BIT     15
`define PMC_LD_GIG_BIT        14
`define PMC_LD_CAUSE_HI       12
`define PMC_LD_CAUSE_LO       8
`define PMC_LD_SRC_HI         4
`define PMC_LD_SRC_LO         0

// Mirror register
`define PMC_MIRROR_RST        16'h0004
`define PMC_MIRROR_BIT        0

// Mac port control fields
`define PMC_MAC_EN_BIT        7
`define PMC_RX_HALF_HI        6
`define PMC_RX_HALF_LO        5
`define PMC_TX_HALF_HI        4
`define PMC_TX_HALF_LO        3
`define PMC_MAC_PORT_RST      8'hD0

// Interrupt status bits
`define PMC_IRQ_WIDTH         5

// Width of restart pulse in clock cycles
`define PMC_RESET_PULSE_CYC   4'h8

// Bus responses
`define PMC_RESP_OKAY         2'h0
`define PMC_RESP_SLVERR       2'h2

`endif

// ===== bench/pmc_regs_checker.sv
/*
 Port checker for the misc control register bank.
 Assumes it is bound onto pmc_regs and sees its ports only.
*/
`timescale 1ns/1ps
module pmc_regs_checker (
	// Clock, reset and bus
	input wire        CLOCK_IN,
	input wire        ARST_N_IN,
	input wire [31:0] AWADDR_IN,
	input wire        AWVALID_IN,
	input wire        AWREADY_OUT,
	input wire [31:0] WDATA_IN,
	input wire [3:0]  WSTRB_IN,
	input wire        WVALID_IN,
	input wire        WREADY_OUT,
	input wire [1:0]  BRESP_OUT,
	input wire        BVALID_OUT,
	input wire        BREADY_IN,
	input wire        ARVALID_IN,
	input wire        ARREADY_OUT,
	input wire [31:0] RDATA_OUT,
	input wire        RVALID_OUT,
	input wire        RREADY_IN,
	// Core controls
	input wire        CORE_RESET_OUT,
	input wire [3:0]  TEST_CHAN_EN_OUT,
	input wire        PORT_MIRROR_OUT,
	input wire        MAC_PORT_ENABLE_OUT,
	input wire [1:0]  RX_FIFO_HALF_LEVEL_OUT,
	input wire [1:0]  TX_FIFO_HALF_LEVEL_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!ARST_N_IN);
	// Write to the control register taken at this edge
	wire aw_w_take = AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
	wire ctl_wr = aw_w_take && AWADDR_IN == 32'h0000007C && WSTRB_IN[1];
	sequence full_req;
		ctl_wr && WDATA_IN[15];
	endsequence
	sequence restart_req;
		ctl_wr && WDATA_IN[14] && !WDATA_IN[15];
	endsequence
	sequence pulse8;
		CORE_RESET_OUT [*8] ##1 !CORE_RESET_OUT;
	endsequence
	chk_rst_width: assert property ($rose(CORE_RESET_OUT) |-> pulse8)
		else $error("core reset pulse width wrong");
	chk_rst_start: assert property (ctl_wr && |WDATA_IN[15:14] |-> ##[1:10] CORE_RESET_OUT)
		else $error("core reset not started");
	chk_full_dflt: assert property (full_req |-> ##[1:4] (MAC_PORT_ENABLE_OUT &&
		RX_FIFO_HALF_LEVEL_OUT == 2'h2 && TX_FIFO_HALF_LEVEL_OUT == 2'h2 && !PORT_MIRROR_OUT))
		else $error("registers not back to defaults");
	chk_restart_keep: assert property (restart_req |=>
		$stable({PORT_MIRROR_OUT, TX_FIFO_HALF_LEVEL_OUT}) [*8])
		else $error("restart changed registers");
	chk_chan_code: assert property (TEST_CHAN_EN_OUT == 4'hF || $onehot(TEST_CHAN_EN_OUT))
		else $error("test channel enables not a valid code");
	chk_b_after: assert property (aw_w_take |=> BVALID_OUT)
		else $error("write response late");
	chk_b_hold: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
		else $error("write response dropped");
	chk_r_after: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
		else $error("read data late");
	chk_r_hold: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
		else $error("read data dropped");
endmodule // pmc_regs_checker

bind pmc_regs pmc_regs_checker chk (.CLOCK_IN, .ARST_N_IN, .AWADDR_IN, .AWVALID_IN,
	.AWREADY_OUT, .WDATA_IN, .WSTRB_IN, .WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT,
	.BREADY_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RVALID_OUT, .RREADY_IN,
	.CORE_RESET_OUT, .TEST_CHAN_EN_OUT, .PORT_MIRROR_OUT, .MAC_PORT_ENABLE_OUT,
	.RX_FIFO_HALF_LEVEL_OUT, .TX_FIFO_HALF_LEVEL_OUT);

// ===== bench/pmc_regs_tb.sv
/*
 Self-checking bench for the misc control register bank.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module pmc_regs_tb;
	reg         clk, rst_n, awv, wv, br, arv, rr;
	reg  [31:0] awa, wd, ara, d;
	reg  [4:0]  ev;
	reg  [1:0]  rsp;
	reg  [3:0]  ws;
	wire        awr, wrdy, bv, arr, rv, crst, ld_en, ld_g, mir, mac, irq;
	wire [1:0]  bresp, rresp, rxl, txl;
	wire [31:0] rd;
	wire [3:0]  tch;
	wire [4:0]  ld_m;
	integer     err_count = 0, compares = 0, i;
	pmc_regs dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n), .AWADDR_IN(awa), .AWVALID_IN(awv),
		.AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(ws), .WVALID_IN(wv), .WREADY_OUT(wrdy),
		.BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(br), .ARADDR_IN(ara), .ARVALID_IN(arv),
		.ARREADY_OUT(arr), .RDATA_OUT(rd), .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rr),
		.DROP_EVENT_IN(ev), .CORE_RESET_OUT(crst), .TEST_CHAN_EN_OUT(tch),
		.LINK_DROP_ENABLE_OUT(ld_en), .LINK_DROP_GIGABIT_CFG_OUT(ld_g),
		.LINK_DROP_SOURCE_MASK_OUT(ld_m), .PORT_MIRROR_OUT(mir), .MAC_PORT_ENABLE_OUT(mac),
		.RX_FIFO_HALF_LEVEL_OUT(rxl), .TX_FIFO_HALF_LEVEL_OUT(txl), .IRQ_OUT(irq));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task report_and_stop;
		begin
			$display("compares %0d mismatches %0d", compares, err_count);
			if (err_count == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	function ok(input integer k);
		ok = k == 0 ? awr && wrdy : k == 1 ? bv : k == 2 ? arr : k == 3 ? rv : k == 4 ? crst : !crst;
	endfunction
	// Wait for a condition seen at a falling edge, then pass the next rising edge
	task hs(input integer k);
		integer n;
		begin
			n = 0;
			@(negedge clk);
			while (!ok(k)) begin
				n = n + 1;
				if (n > 60) begin
					err_count = err_count + 1;
					report_and_stop;
				end
				@(negedge clk);
			end
			rsp = k == 1 ? bresp : rresp;
			d = rd;
			@(posedge clk);
		end
	endtask
	task axi_wr(input [31:0] a, input [31:0] v, input [1:0] e);
		begin
			awa <= a;
			wd <= v;
			awv <= 1'h1;
			wv <= 1'h1;
			hs(0);
			awv <= 1'h0;
			wv <= 1'h0;
			@(posedge clk);
			br <= 1'h1;
			hs(1);
			br <= 1'h0;
			check(rsp, e);
		end
	endtask
	task axi_rd(input [31:0] a, input [31:0] exp, input [1:0] e);
		begin
			ara <= a;
			arv <= 1'h1;
			hs(2);
			arv <= 1'h0;
			@(posedge clk);
			rr <= 1'h1;
			hs(3);
			rr <= 1'h0;
			check(d, exp);
			check(rsp, e);
		end
	endtask
	task pulse(input [4:0] p);
		begin
			ev <= p;
			repeat (6) @(posedge clk);
			ev <= 5'h00;
			repeat (4) @(posedge clk);
		end
	endtask
	task t_defaults;
		begin
			axi_rd(32'h7C, 32'h0, 2'h0);
			axi_rd(32'h94, 32'h400, 2'h0);
			axi_rd(32'hB4, 32'h0, 2'h0);
			axi_rd(32'hC4, 32'h4, 2'h0);
			axi_rd(32'hC8, 32'hD0, 2'h0);
			check(mac, 1'h1);
			check(rxl, 2'h2);
			check(txl, 2'h2);
			$display("test defaults done");
		end
	endtask
	task t_ctrl;
		begin
			axi_wr(32'h7C, 32'h3FFF, 2'h0);
			axi_rd(32'h7C, 32'h0, 2'h0);
			axi_wr(32'hC4, 32'h1, 2'h0);
			axi_wr(32'hC8, 32'h18, 2'h0);
			check({mir, mac, rxl, txl}, 6'h23);
			axi_wr(32'h7C, 32'h4000, 2'h0);
			hs(4);
			hs(5);
			axi_rd(32'hC4, 32'h5, 2'h0);
			axi_rd(32'hC8, 32'h18, 2'h0);
			axi_rd(32'h7C, 32'h0, 2'h0);
			axi_wr(32'h7C, 32'h8000, 2'h0);
			hs(4);
			hs(5);
			axi_rd(32'hC4, 32'h4, 2'h0);
			axi_rd(32'hC8, 32'hD0, 2'h0);
			axi_rd(32'h7C, 32'h0, 2'h0);
			$display("test control done");
		end
	endtask
	task t_chan;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				axi_wr(32'h94, i << 5, 2'h0);
				axi_rd(32'h94, 32'h400 | (i << 5), 2'h0);
				check(tch, i >= 4 ? 4'hF : 4'h1 << (i % 4));
			end
			$display("test channel done");
		end
	endtask
	task t_drop;
		begin
			axi_wr(32'h104, 32'h1F, 2'h0);
			axi_wr(32'hB4, 32'hC015, 2'h0);
			check({ld_en, ld_g, ld_m}, 7'h75);
			pulse(5'h1F);
			check(irq, 1'h1);
			axi_rd(32'hB4, 32'hD515, 2'h0);
			axi_rd(32'hB4, 32'hC015, 2'h0);
			axi_rd(32'h100, 32'h15, 2'h0);
			repeat (3) @(posedge clk);
			check(irq, 1'h0);
			pulse(5'h08);
			axi_rd(32'hB4, 32'hC015, 2'h0);
			pulse(5'h04);
			axi_rd(32'hB4, 32'hC415, 2'h0);
			axi_wr(32'h104, 32'h0, 2'h0);
			pulse(5'h01);
			check(irq, 1'h0);
			axi_rd(32'h100, 32'h5, 2'h0);
			axi_wr(32'hB4, 32'h1F, 2'h0);
			pulse(5'h1F);
			axi_rd(32'hB4, 32'h11F, 2'h0);
			ws <= 4'h1;
			axi_wr(32'hB4, 32'hC0FF, 2'h0);
			ws <= 4'hF;
			axi_rd(32'hB4, 32'h1F, 2'h0);
			$display("test drop done");
		end
	endtask
	task t_bad;
		begin
			axi_rd(32'h200, 32'h0, 2'h2);
			axi_rd(32'h7E, 32'h0, 2'h2);
			axi_wr(32'h200, 32'hFFFF, 2'h2);
			$display("test unmapped done");
		end
	endtask
	initial begin
		rst_n = 1'h0;
		{awv, wv, br, arv, rr} = 5'h00;
		{awa, wd, ara} = 96'h0;
		ev = 5'h00;
		ws = 4'hF;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_defaults;
		t_ctrl;
		t_chan;
		t_drop;
		t_bad;
		report_and_stop;
	end
endmodule // pmc_regs_tb
